//--- rtl/sdl_defs.vh
// Purpose: shared constants of the start-up delay and output latch block
// Assumes: 20 MHz system clock, byte addressed classic wishbone registers
// Notes: times are kept in their own unit, cycle counts are derived here
`ifndef SDL_DEFS_VH
`define SDL_DEFS_VH

`define SDL_CLK_KHZ 20000
`define SDL_TICK_MS 10
`define SDL_TICK_CYC 24'h030d40
`define SDL_TICKS_PER_SEC 7'h64

`define SDL_ADR_CFG 6'h00
`define SDL_ADR_SSTIME 6'h04
`define SDL_ADR_CMD 6'h08
`define SDL_ADR_STATE 6'h0c
`define SDL_ADR_IRQ_STAT 6'h10
`define SDL_ADR_IRQ_MASK 6'h14

`define SDL_CFG_DLY_LSB 0
`define SDL_CFG_ASG_LSB 4
`define SDL_CFG_LAT_LSB 8
`define SDL_CFG_RST 12'h000
`define SDL_SSTIME_RST 14'h0064
`define SDL_MASK_RST 3'h0

`define SDL_CMD_RELEASE 0
`define SDL_CMD_RESTART 1

`define SDL_IRQ_DLY_END 0
`define SDL_IRQ_SSTILL 1
`define SDL_IRQ_LATCH 2

`define SDL_SEL_OVER 4'h9
`define SDL_SEL_REMOTE 4'ha

`endif

//--- rtl/sdl_tick.v
// Purpose: free running base tick of one time step
// Assumes: tick_cyc is at least two
// Notes: one pulse of one clock every tick_cyc clocks
`timescale 1ns/10ps
`include "sdl_defs.vh"

module sdl_tick #(
  parameter [23:0] TICK_CYC = `SDL_TICK_CYC
) (
  clk,
  sys_rst,
  tick
);
  input wire clk;
  input wire sys_rst;
  output reg tick;

  reg [23:0] cnt_q;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 24'h000000;
      tick <= 1'b0;
    end else if (cnt_q == TICK_CYC - 24'h000001) begin
      cnt_q <= 24'h000000;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 24'h000001;
      tick <= 1'b0;
    end
  end
endmodule

//--- rtl/sdl_top.v
// Purpose: start-up delay, output latch and standstill logic of a speed monitor
// Assumes: all inputs synchronous to clk; cmp_alarm high means output switched
// Notes: registers over classic wishbone, one level interrupt
//
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/10ps
`include "sdl_defs.vh"

module sdl_top #(
  parameter [23:0] TICK_CYC = `SDL_TICK_CYC
) (
  clk,
  sys_rst,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_sel_i,
  wb_dat_i,
  wb_dat_o,
  wb_ack_o,
  cmp_alarm,
  over_set,
  zero_freq,
  remote_delay,
  key_release,
  ctrl_release,
  out_q,
  irq_q
);
  input wire clk;
  input wire sys_rst;
  input wire wb_cyc_i;
  input wire wb_stb_i;
  input wire wb_we_i;
  input wire [5:0] wb_adr_i;
  input wire [3:0] wb_sel_i;
  input wire [31:0] wb_dat_i;
  output reg [31:0] wb_dat_o;
  output reg wb_ack_o;
  input wire [2:0] cmp_alarm;
  input wire over_set;
  input wire zero_freq;
  input wire remote_delay;
  input wire key_release;
  input wire ctrl_release;
  output reg [2:0] out_q;
  output reg irq_q;

  // ST_DONE also stands for the codes that ask for no delay at all
  localparam [2:0] ST_START = 3'h0;
  localparam [2:0] ST_TIMED = 3'h1;
  localparam [2:0] ST_OVER = 3'h2;
  localparam [2:0] ST_REMOTE = 3'h3;
  localparam [2:0] ST_DONE = 3'h4;

  // seconds of a fixed delay code, zero where the code is not timed
  function [7:0] dly_secs;
    input [3:0] code;
    begin
      case (code)
        4'h1: dly_secs = 8'h01;
        4'h2: dly_secs = 8'h02;
        4'h3: dly_secs = 8'h04;
        4'h4: dly_secs = 8'h08;
        4'h5: dly_secs = 8'h10;
        4'h6: dly_secs = 8'h20;
        4'h7: dly_secs = 8'h40;
        4'h8: dly_secs = 8'h80;
        default: dly_secs = 8'h00;
      endcase
    end
  endfunction

  // byte lane merge of a write
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] new_v;
    input [3:0] sel;
    integer k;
    begin
      wmerge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          wmerge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  wire tick;
  reg [11:0] cfg_q;
  reg [11:0] cfg_d;
  reg [13:0] sstime_q;
  reg [13:0] sstime_d;
  reg [2:0] imask_q;
  reg [2:0] imask_d;
  reg [2:0] istat_q;
  reg [2:0] istat_d;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [6:0] sub_q;
  reg [6:0] sub_d;
  reg [7:0] sec_q;
  reg [7:0] sec_d;
  reg [13:0] zcnt_q;
  reg [13:0] zcnt_d;
  reg still_q;
  reg still_d;
  reg dly_q;
  reg dly_d;
  reg [2:0] held_q;
  reg [2:0] held_d;
  reg [31:0] rdat;
  reg [31:0] wr_word;
  reg cmd_release;
  reg cmd_restart;

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;
  wire [3:0] dly_sel = cfg_q[`SDL_CFG_DLY_LSB +: 4];
  wire [2:0] asg_mask = cfg_q[`SDL_CFG_ASG_LSB +: 3];
  wire [2:0] lat_mask = cfg_q[`SDL_CFG_LAT_LSB +: 3];
  wire lat_still = cfg_q[`SDL_CFG_LAT_LSB + 3];
  wire [2:0] gated;
  wire release_any;
  wire release_still;
  wire [2:0] held_next;
  genvar g;

  sdl_tick #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  // register writes and command strobes
  always @* begin
    cfg_d = cfg_q;
    sstime_d = sstime_q;
    imask_d = imask_q;
    cmd_release = 1'b0;
    cmd_restart = 1'b0;
    wr_word = 32'h00000000;
    if (wb_wr) begin
      case (wb_adr_i)
        `SDL_ADR_CFG: begin
          wr_word = wmerge({20'h00000, cfg_q}, wb_dat_i, wb_sel_i);
          cfg_d = wr_word[11:0];
        end
        `SDL_ADR_SSTIME: begin
          wr_word = wmerge({18'h00000, sstime_q}, wb_dat_i, wb_sel_i);
          sstime_d = wr_word[13:0];
        end
        `SDL_ADR_CMD: begin
          cmd_release = wb_sel_i[0] & wb_dat_i[`SDL_CMD_RELEASE];
          cmd_restart = wb_sel_i[0] & wb_dat_i[`SDL_CMD_RESTART];
        end
        `SDL_ADR_IRQ_MASK: begin
          wr_word = wmerge({29'h00000000, imask_q}, wb_dat_i, wb_sel_i);
          imask_d = wr_word[2:0];
        end
        default: begin
          wr_word = 32'h00000000;
        end
      endcase
    end
  end

  // read mux, unmapped addresses read zero
  always @* begin
    case (wb_adr_i)
      `SDL_ADR_CFG: rdat = {20'h00000, cfg_q};
      `SDL_ADR_SSTIME: rdat = {18'h00000, sstime_q};
      `SDL_ADR_STATE: rdat = {23'h000000, sec_q[0], held_q, still_q, dly_q, out_q};
      `SDL_ADR_IRQ_STAT: rdat = {29'h00000000, istat_q};
      `SDL_ADR_IRQ_MASK: rdat = {29'h00000000, imask_q};
      default: rdat = 32'h00000000;
    endcase
  end

  // delay sequencer; delay restarts from reset release or a restart command
  always @* begin
    state_d = state_q;
    sub_d = sub_q;
    sec_d = sec_q;
    case (state_q)
      ST_START: begin
        sub_d = 7'h00;
        sec_d = 8'h00;
        if (dly_secs(dly_sel) != 8'h00) begin
          state_d = ST_TIMED;
        end else if (dly_sel == `SDL_SEL_OVER) begin
          state_d = ST_OVER;
        end else if (dly_sel == `SDL_SEL_REMOTE) begin
          state_d = ST_REMOTE;
        end else begin
          state_d = ST_DONE;
        end
      end
      ST_TIMED: begin
        // the tick runs free, so the first second may be up to one tick short
        if (tick) begin
          if (sub_q == `SDL_TICKS_PER_SEC - 7'h01) begin
            sub_d = 7'h00;
            sec_d = sec_q + 8'h01;
          end else begin
            sub_d = sub_q + 7'h01;
          end
        end
        if (sec_q == dly_secs(dly_sel)) begin
          state_d = ST_DONE;
        end
      end
      ST_OVER: begin
        if (over_set) begin
          state_d = ST_DONE;
        end
      end
      ST_REMOTE: begin
        state_d = ST_REMOTE;
      end
      ST_DONE: begin
        state_d = ST_DONE;
      end
      default: begin
        state_d = ST_START;
      end
    endcase
    if (cmd_restart) begin
      state_d = ST_START;
    end
  end

  // delay flag: timed and first-overstep states hold it, remote mode follows the pin
  always @* begin
    case (state_d)
      ST_START: dly_d = dly_q;
      ST_TIMED: dly_d = 1'b1;
      ST_OVER: dly_d = 1'b1;
      ST_REMOTE: dly_d = remote_delay;
      default: dly_d = 1'b0;
    endcase
  end

  // standstill: any nonzero frequency restarts the wait
  // counted in whole ticks; a standstill time of zero declares it at once
  always @* begin
    zcnt_d = zcnt_q;
    still_d = still_q;
    if (!zero_freq) begin
      zcnt_d = 14'h0000;
      still_d = 1'b0;
    end else if (zcnt_q >= sstime_q) begin
      still_d = 1'b1;
    end else if (tick) begin
      zcnt_d = zcnt_q + 14'h0001;
    end
  end

  // release is level sensitive: a key held down releases on every clock
  assign release_any = key_release | ctrl_release | cmd_release;
  // standstill release only where the latch setting asks for it
  assign release_still = lat_still & still_q;

  // per output: delay gate first, then latch; set wins over release so a
  // trigger in the release cycle is kept
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_out
      assign gated[g] = cmp_alarm[g] & ~(dly_q & asg_mask[g]);
      assign held_next[g] = (held_q[g] & ~(release_any | release_still))
                            | (gated[g] & lat_mask[g]);
    end
  endgenerate

  // held bits of outputs taken out of the latch mask drop at once
  always @* begin
    held_d = held_next & lat_mask;
  end

  // status flags: an event in the clearing cycle wins
  always @* begin
    istat_d = istat_q;
    if (wb_wr && wb_adr_i == `SDL_ADR_IRQ_STAT && wb_sel_i[0]) begin
      istat_d = istat_q & ~wb_dat_i[2:0];
    end
    if (dly_q && !dly_d) begin
      istat_d[`SDL_IRQ_DLY_END] = 1'b1;
    end
    if (still_d && !still_q) begin
      istat_d[`SDL_IRQ_SSTILL] = 1'b1;
    end
    if (|(held_d & ~held_q)) begin
      istat_d[`SDL_IRQ_LATCH] = 1'b1;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= `SDL_CFG_RST;
      sstime_q <= `SDL_SSTIME_RST;
      imask_q <= `SDL_MASK_RST;
      istat_q <= 3'h0;
      state_q <= ST_START;
      sub_q <= 7'h00;
      sec_q <= 8'h00;
      zcnt_q <= 14'h0000;
      still_q <= 1'b0;
      dly_q <= 1'b0;
      held_q <= 3'h0;
      out_q <= 3'h0;
      irq_q <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      cfg_q <= cfg_d;
      sstime_q <= sstime_d;
      imask_q <= imask_d;
      istat_q <= istat_d;
      state_q <= state_d;
      sub_q <= sub_d;
      sec_q <= sec_d;
      zcnt_q <= zcnt_d;
      still_q <= still_d;
      dly_q <= dly_d;
      held_q <= held_d;
      out_q <= gated | held_next;
      irq_q <= |(istat_d & imask_d);
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= rdat;
      end
    end
  end
endmodule

//--- tb/sdl_monitor.sv
// Purpose: port checker of sdl_top
// Assumes: one clock, async high reset
// Notes: config is unseen here, so only config-free relations
`timescale 1ns/10ps
module sdl_mon #(
  parameter [23:0] TICK_CYC = 24'h000002
) (
  input wire clk,
  input wire sys_rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [2:0] cmp_alarm,
  input wire key_release,
  input wire ctrl_release,
  input wire [2:0] out_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_timely_a: assert property (req |=> wb_ack_o)
    else $error("ack not in next cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(req))
    else $error("ack without request");
  key_clear_a: assert property (key_release && !cmp_alarm |=> !out_q)
    else $error("key did not release");
  ctrl_clear_a: assert property (ctrl_release && !cmp_alarm |=> !out_q)
    else $error("control input did not release");
  out_cause_a: assert property (!(out_q & ~$past(out_q) & ~$past(cmp_alarm)))
    else $error("output switched without alarm");
  unmap_zero_a: assert property (req && !wb_we_i && wb_adr_i[5:2] > 4'h5 |=> !wb_dat_o)
    else $error("unmapped read not zero");
  cmd_zero_a: assert property (req && !wb_we_i && wb_adr_i == 6'h08 |=> !wb_dat_o)
    else $error("command read not zero");
endmodule
bind sdl_top sdl_mon #(.TICK_CYC(TICK_CYC)) u_mon (.clk(clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_alarm(cmp_alarm),
  .key_release(key_release), .ctrl_release(ctrl_release), .out_q(out_q));

//--- tb/sdl_shaft.sv
// Purpose: shaft pulse source seen as zero and over-set flags
// Assumes: bench sets spin and fast at clock edges
// Notes: flags lag one cycle, like a real measurement
`timescale 1ns/10ps
module sdl_shaft (
  input wire clk,
  input wire spin,
  input wire fast,
  output reg zero_freq,
  output reg over_set
);
  initial begin
    zero_freq = 1'b0;
    over_set = 1'b0;
  end
  always @(posedge clk) begin
    zero_freq <= !spin;
    over_set <= spin & fast;
  end
endmodule

//--- tb/sdl_top_tb_top.sv
// Purpose: self-checking bench of sdl_top
// Assumes: TICK_CYC 2, so one second is 200 clocks
// Notes: reads are scored from a queue by a watcher
`timescale 1ns/10ps
`include "sdl_defs.vh"
module sdl_top_tb_top;
  localparam [5:0] CF = `SDL_ADR_CFG;
  localparam [5:0] CM = `SDL_ADR_CMD;
  localparam [5:0] ST = `SDL_ADR_STATE;
  reg clk, sys_rst, cyc, we, spin, fast, remote, key, ctrl;
  reg [3:0] sel;
  reg [5:0] adr;
  reg [31:0] wdat, lf;
  reg [63:0] e;
  reg [2:0] alarm, m;
  wire [31:0] rdat;
  wire ack, irq, zf, os;
  wire [2:0] outs;
  integer bad_count, cmp_count, c, n;
  reg [63:0] q[$];
  sdl_top #(.TICK_CYC(24'h000002)) uut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cmp_alarm(alarm), .over_set(os), .zero_freq(zf),
    .remote_delay(remote), .key_release(key), .ctrl_release(ctrl), .out_q(outs),
    .irq_q(irq));
  sdl_shaft shaft (.clk(clk), .spin(spin), .fast(fast), .zero_freq(zf), .over_set(os));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task print_verdict;
    begin
      $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wb(input w, input [5:0] a, input [31:0] d, input [31:0] mk, input [31:0] x);
    begin
      if (!w) q.push_back({mk, x});
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (!ack && n < 50);
      if (!ack) begin
        bad_count = bad_count + 1;
        print_verdict;
      end else
        cyc <= 1'b0;
    end
  endtask
  task wr(input [5:0] a, input [31:0] d);
    wb(1'b1, a, d, 32'h0, 32'h0);
  endtask
  task rd(input [5:0] a, input [31:0] mk, input [31:0] x);
    wb(1'b0, a, 32'h0, mk, x);
  endtask
  task pulse_alarm;
    begin
      alarm <= 3'h7;
      @(posedge clk);
      alarm <= 3'h0;
      repeat (3) @(posedge clk);
    end
  endtask
  // watcher scores each read as its ack appears
  always @(posedge clk) begin
    if (ack && !we) begin
      e = q.pop_front();
      chk(rdat & e[63:32], e[31:0]);
    end
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    sys_rst = 1'b1;
    {cyc, we, adr, wdat, alarm, fast, remote, key, ctrl} = 47'h0;
    sel = 4'hf;
    spin = 1'b1;
    bad_count = 0;
    cmp_count = 0;
    lf = 32'h6a91c41a;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(CF, 32'hfff, 32'h0);
    rd(`SDL_ADR_SSTIME, 32'h3fff, 32'h64);
    rd(CM, 32'hffffffff, 32'h0);
    rd(6'h18, 32'hffffffff, 32'h0);
    $display("reset values done");
    alarm <= 3'h7;
    for (c = 1; c <= 8; c = c + 1) begin
      lf = lfsr(lf);
      m = lf[2:0];
      wr(CF, {25'h0, m, c[3:0]});
      wr(CM, 32'h2);
      repeat ((200 << (c - 1)) - 10) @(posedge clk);
      rd(ST, 32'h1f, {29'h1, ~m});
      repeat (20) @(posedge clk);
      rd(ST, 32'h1f, 32'h7);
    end
    $display("fixed delays done");
    wr(CF, 32'h79);
    wr(CM, 32'h2);
    rd(ST, 32'h1f, 32'h8);
    fast <= 1'b1;
    repeat (5) @(posedge clk);
    fast <= 1'b0;
    repeat (3) @(posedge clk);
    rd(ST, 32'h1f, 32'h7);
    wr(CF, 32'h7a);
    wr(CM, 32'h2);
    for (c = 0; c < 4; c = c + 1) begin
      remote <= c[0];
      repeat (3) @(posedge clk);
      rd(ST, 32'h1f, c[0] ? 32'h8 : 32'h7);
    end
    $display("over-set and remote delay done");
    alarm <= 3'h0;
    wr(CF, 32'h500);
    wr(CM, 32'h2);
    for (c = 0; c < 3; c = c + 1) begin
      pulse_alarm;
      rd(ST, 32'hff, 32'ha5);
      @(negedge clk) chk({29'h0, outs}, 32'h5);
      @(posedge clk);
      if (c == 2)
        wr(CM, 32'h1);
      else begin
        key <= !c[0];
        ctrl <= c[0];
        @(posedge clk);
        key <= 1'b0;
        ctrl <= 1'b0;
      end
      repeat (2) @(posedge clk);
      rd(ST, 32'hff, 32'h0);
    end
    $display("latch release done");
    wr(CF, 32'hd00);
    wr(`SDL_ADR_SSTIME, 32'ha);
    pulse_alarm;
    spin <= 1'b0;
    repeat (15) @(posedge clk);
    spin <= 1'b1;
    @(posedge clk);
    spin <= 1'b0;
    repeat (8) @(posedge clk);
    rd(ST, 32'hff, 32'ha5);
    repeat (40) @(posedge clk);
    rd(ST, 32'hff, 32'h10);
    spin <= 1'b1;
    $display("standstill done");
    @(negedge clk) chk({31'h0, irq}, 32'h0);
    rd(`SDL_ADR_IRQ_STAT, 32'h7, 32'h7);
    wr(`SDL_ADR_IRQ_MASK, 32'h2);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(`SDL_ADR_IRQ_STAT, 32'h7);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(`SDL_ADR_IRQ_STAT, 32'h7, 32'h0);
    repeat (3) @(posedge clk);
    $display("interrupt done");
    print_verdict;
  end
endmodule
